// ### rtl/fe_tx_pkg.sv
/*
   Constants, state type and 4B/5B encode table for the 100 Mb/s transmit coding path.
   Assumes a single 250 MHz core clock with the serial rate derived from it.
*/
package fe_tx_pkg;

   // ****************************************
   // clock and serial timing
   // ****************************************
   localparam int CLK_RATE_MHZ = 250;
   localparam int SER_RATE_MHZ = 125;
   localparam int CYC_PER_BIT  = CLK_RATE_MHZ / SER_RATE_MHZ;
   localparam int BITS_PER_CG  = 5;

   localparam logic       BIT_PH_LAST  = 1'(CYC_PER_BIT - 1);
   localparam logic [2:0] BIT_IDX_LAST = 3'(BITS_PER_CG - 1);
   localparam logic [2:0] BIT_IDX_ONE  = 3'h1;

   // ****************************************
   // scrambler
   // ****************************************
   localparam int         LFSR_W      = 11;
   localparam int         LFSR_TAP_HI = 10;
   localparam int         LFSR_TAP_LO = 8;
   localparam int         ADDR_W      = 5;
   localparam logic [5:0] SEED_PAD    = 6'h2b;
   localparam logic [1:0] INIT_DONE   = 2'h3;
   localparam logic [1:0] INIT_STEP   = 2'h1;

   // ****************************************
   // line coding
   // ****************************************
   localparam logic [1:0] MLT_PH_POS  = 2'h1;
   localparam logic [1:0] MLT_PH_NEG  = 2'h3;
   localparam logic [1:0] MLT_PH_STEP = 2'h1;

   // ****************************************
   // nibble path and buffer
   // ****************************************
   localparam int NIB_W      = 4;
   localparam int ENTRY_W    = 6;
   localparam int FIFO_DEPTH = 16;

   typedef logic [4:0] cg_t;

   localparam cg_t CG_IDLE = 5'h1f;
   localparam cg_t CG_J    = 5'h18;
   localparam cg_t CG_K    = 5'h11;
   localparam cg_t CG_T    = 5'h0d;
   localparam cg_t CG_R    = 5'h07;
   localparam cg_t CG_HALT = 5'h04;

   localparam logic [3:0] NIB_IDLE    = 4'h0;
   localparam logic [3:0] NIB_SSD     = 4'h5;
   localparam logic [3:0] NIB_ESD     = 4'h0;
   localparam logic [3:0] NIB_INVALID = 4'h6;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SSD2 = 2'b01,
      ST_DATA = 2'b10,
      ST_ESD2 = 2'b11
   } tx_state_e;

   function automatic cg_t enc_4b5b(input logic [3:0] nib);
      cg_t cg;
      case (nib)
         4'h0: cg = 5'h1e;
         4'h1: cg = 5'h09;
         4'h2: cg = 5'h14;
         4'h3: cg = 5'h15;
         4'h4: cg = 5'h0a;
         4'h5: cg = 5'h0b;
         4'h6: cg = 5'h0e;
         4'h7: cg = 5'h0f;
         4'h8: cg = 5'h12;
         4'h9: cg = 5'h13;
         4'ha: cg = 5'h16;
         4'hb: cg = 5'h17;
         4'hc: cg = 5'h1a;
         4'hd: cg = 5'h1b;
         4'he: cg = 5'h1c;
         default: cg = 5'h1d;
      endcase
      return cg;
   endfunction

endpackage

// ### rtl/fifo_if.sv
/*
   Valid/ready carrier between the nibble sampler, the buffer and the encoder.
   Assumes both sides sit on the same clock.
*/
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 6) ();
   logic         push_valid;
   logic         push_ready;
   logic [W-1:0] push_data;
   logic         pop_valid;
   logic         pop_ready;
   logic [W-1:0] pop_data;

   modport fill  (output push_valid, push_data, input push_ready);
   modport drain (input pop_valid, pop_data, output pop_ready);
   modport store (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
endinterface

// ### rtl/sym_fifo.sv
/*
   Synchronous FIFO with parameter width and depth, valid/ready on both sides.
   Assumes DEPTH is a power of two and W matches the carrier width.
*/
`timescale 1ns/1ps
module sym_fifo #(
   parameter int W     = 6,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rstn,
   fifo_if.store    f
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   logic         full;
   logic         empty;

   assign empty        = (wr_q == rd_q);
   assign full         = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign f.push_ready = !full;
   assign f.pop_valid  = !empty;
   assign f.pop_data   = mem[rd_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (f.push_valid && !full) begin
         mem[wr_q[AW-1:0]] <= f.push_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
      end else if (f.push_valid && !full) begin
         wr_q <= wr_q + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_q <= '0;
      end else if (f.pop_ready && !empty) begin
         rd_q <= rd_q + (AW+1)'(1);
      end
   end
endmodule

// ### rtl/cg_decoder.sv
/*
   Receive-side 5B to 4B lookup with invalid and misplaced control detection.
   Assumes the caller says whether the code-group lies inside a data field.
*/
`timescale 1ns/1ps
module cg_decoder
   import fe_tx_pkg::*;
(
   input  wire logic [4:0] code_group,
   input  wire logic       in_frame,
   output logic [3:0]      nibble,
   output logic            error
);
   always_comb begin
      nibble = NIB_INVALID;
      error  = 1'b0;
      case (code_group)
         5'h1e: nibble = 4'h0;
         5'h09: nibble = 4'h1;
         5'h14: nibble = 4'h2;
         5'h15: nibble = 4'h3;
         5'h0a: nibble = 4'h4;
         5'h0b: nibble = 4'h5;
         5'h0e: nibble = 4'h6;
         5'h0f: nibble = 4'h7;
         5'h12: nibble = 4'h8;
         5'h13: nibble = 4'h9;
         5'h16: nibble = 4'ha;
         5'h17: nibble = 4'hb;
         5'h1a: nibble = 4'hc;
         5'h1b: nibble = 4'hd;
         5'h1c: nibble = 4'he;
         5'h1d: nibble = 4'hf;
         CG_IDLE: nibble = NIB_IDLE;
         CG_J, CG_K: nibble = NIB_SSD;
         CG_T, CG_R: nibble = NIB_ESD;
         default: error = 1'b1;
      endcase
      // control codes inside a data field count as invalid
      if (in_frame && (code_group == CG_IDLE || code_group == CG_J || code_group == CG_K ||
                       code_group == CG_T || code_group == CG_R)) begin
         error = 1'b1;
      end
      if (error) begin
         nibble = NIB_INVALID;
      end
   end
endmodule

// ### rtl/fe_tx_coding_path.sv
/*
   100 Mb/s transmit coding path: nibble sampling, 4B5B encoding with
   delimiters and HALT substitution, serialiser, scrambler, NRZI and MLT-3
   split; plus the registered receive 5B4B lookup.
   Assumes MII transmit pins and the address strap come from outside the
   clock domain; receive code-groups come from logic on clk.
*/
`timescale 1ns/1ps
// Summary of operation
// - scrambler is 11-bit closed-loop LFSR, one step/bit
// - serial bit XORed with LFSR output
// - scrambler seed taken from PHY address strap
// - NRZI stage always present, never bypassed
// - sixteen data nibbles map to fixed code-groups
// - idle is 11111, decodes to 0000
// - start pair 11000 then 10001, nibble 0101
// - end pair 01101 then 00111, nibble 0000
// - HALT error symbol is 00100
// - invalid code-groups decode to 6h with error
// - control codes inside data flag an error
// - NRZI split into two alternating one streams
// - enable plus error sends HALT per nibble after J/K
// - delimiters never replaced by HALT
// - line carries only three-level coded data
// - J/K replace first two preamble nibbles; T/R end frame
// - idles follow until enable returns
// - code-groups serialised at 125 MHz
module fe_tx_coding_path
   import fe_tx_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              tx_en,
   input  wire logic              tx_er,
   input  wire logic [NIB_W-1:0]  txd,
   input  wire logic [ADDR_W-1:0] phy_address_strap,
   input  wire logic [4:0]        rx_code_group,
   input  wire logic              rx_code_valid,
   input  wire logic              rx_in_frame,
   output logic                   mlt_pos,
   output logic                   mlt_neg,
   output logic                   tx_fifo_full,
   output logic [NIB_W-1:0]       rx_nibble,
   output logic                   rx_nibble_valid,
   output logic                   rx_error
);

   // ****************************************
   // declarations
   // ****************************************
   logic [ENTRY_W-1:0] tx_meta_q;
   logic [ENTRY_W-1:0] tx_sync_q;
   logic [ADDR_W-1:0]  addr_meta_q;
   logic [ADDR_W-1:0]  addr_sync_q;
   logic [1:0]         init_cnt_q;
   logic               seeded;
   logic               bit_ph_q;
   logic [2:0]         bit_idx_q;
   logic               bit_stb;
   logic               cg_stb;
   tx_state_e          state_q;
   tx_state_e          state_d;
   cg_t                sh_q;
   cg_t                cg_q;
   cg_t                cg_d;
   cg_t                enc_cg;
   logic [ENTRY_W-1:0] cur_entry;
   logic               cur_en;
   logic               cur_er;
   logic [NIB_W-1:0]   cur_nib;
   logic [LFSR_W-1:0]  lfsr_q;
   logic [LFSR_W-1:0]  lfsr_next;
   logic [LFSR_W-1:0]  seed;
   logic               scr_bit;
   logic               nrzi_q;
   logic [1:0]         mlt_ph_q;
   logic [1:0]         mlt_ph_d;
   logic [NIB_W-1:0]   dec_nibble;
   logic               dec_err;
   logic               mlt_pos_q;
   logic               mlt_neg_q;
   logic               tx_fifo_full_q;
   logic [NIB_W-1:0]   rx_nibble_q;
   logic               rx_nibble_valid_q;
   logic               rx_error_q;
   fifo_if #(.W(ENTRY_W)) nib_fifo ();

   // ****************************************
   // input synchronisers
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_meta_q <= '0;
         tx_sync_q <= '0;
      end else begin
         tx_meta_q <= {tx_en, tx_er, txd};
         tx_sync_q <= tx_meta_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_meta_q <= '0;
         addr_sync_q <= '0;
      end else begin
         addr_meta_q <= phy_address_strap;
         addr_sync_q <= addr_meta_q;
      end
   end

   // ****************************************
   // start-up: wait for the strap to settle
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         init_cnt_q <= '0;
      end else if (init_cnt_q != INIT_DONE) begin
         init_cnt_q <= init_cnt_q + INIT_STEP;
      end
   end

   assign seeded = (init_cnt_q == INIT_DONE);

   // ****************************************
   // bit and code-group timing
   // ****************************************
   assign bit_stb = (bit_ph_q == BIT_PH_LAST);
   assign cg_stb  = bit_stb && (bit_idx_q == BIT_IDX_LAST);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bit_ph_q <= 1'b0;
      end else begin
         bit_ph_q <= ~bit_ph_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bit_idx_q <= '0;
      end else if (cg_stb) begin
         bit_idx_q <= '0;
      end else if (bit_stb) begin
         bit_idx_q <= bit_idx_q + BIT_IDX_ONE;
      end
   end

   // ****************************************
   // nibble sampling through the buffer
   // ****************************************
   // one nibble per code-group slot; a full buffer drops the sample
   assign nib_fifo.push_valid = cg_stb;
   assign nib_fifo.push_data  = tx_sync_q;
   assign nib_fifo.pop_ready  = cg_stb && seeded;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_fifo_full_q <= 1'b0;
      end else begin
         tx_fifo_full_q <= !nib_fifo.push_ready;
      end
   end
   sym_fifo #(
      .W     (ENTRY_W),
      .DEPTH (FIFO_DEPTH)
   ) u_nib_fifo (
      .clk  (clk),
      .rstn (rstn),
      .f    (nib_fifo)
   );
   // underrun reads as enable low
   assign cur_entry = nib_fifo.pop_valid ? nib_fifo.pop_data : '0;
   assign cur_en    = cur_entry[ENTRY_W-1];
   assign cur_er    = cur_entry[ENTRY_W-2];
   assign cur_nib   = cur_entry[NIB_W-1:0];
   assign enc_cg    = enc_4b5b(cur_nib);

   // ****************************************
   // code-group encoder
   // ****************************************
   always_comb begin
      state_d = state_q;
      cg_d    = CG_IDLE;
      case (state_q)
         ST_IDLE: begin
            if (cur_en) begin
               cg_d    = CG_J;
               state_d = ST_SSD2;
            end else begin
               cg_d = CG_IDLE;
            end
         end
         ST_SSD2: begin
            cg_d    = CG_K;
            state_d = ST_DATA;
         end
         ST_DATA: begin
            if (!cur_en) begin
               cg_d    = CG_T;
               state_d = ST_ESD2;
            end else if (cur_er) begin
               cg_d = CG_HALT;
            end else begin
               cg_d = enc_cg;
            end
         end
         ST_ESD2: begin
            cg_d    = CG_R;
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         cg_q    <= CG_IDLE;
      end else if (cg_stb && seeded) begin
         state_q <= state_d;
         cg_q    <= cg_d;
      end
   end

   // ****************************************
   // serialiser, first bit leftmost
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sh_q <= CG_IDLE;
      end else if (cg_stb) begin
         sh_q <= seeded ? cg_d : CG_IDLE;
      end else if (bit_stb) begin
         sh_q <= {sh_q[3:0], 1'b0};
      end
   end

   // ****************************************
   // scrambler
   // ****************************************
   assign seed      = {addr_sync_q, SEED_PAD};
   assign lfsr_next = {lfsr_q[LFSR_W-2:0], lfsr_q[LFSR_TAP_HI] ^ lfsr_q[LFSR_TAP_LO]};
   assign scr_bit   = sh_q[4] ^ lfsr_q[LFSR_TAP_HI];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lfsr_q <= {{(LFSR_W-1){1'b0}}, 1'b1};
      end else if (!seeded || lfsr_q == '0) begin
         lfsr_q <= seed;
      end else if (bit_stb) begin
         lfsr_q <= lfsr_next;
      end
   end

   // ****************************************
   // NRZI and MLT-3 split
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nrzi_q <= 1'b0;
      end else if (bit_stb) begin
         nrzi_q <= nrzi_q ^ scr_bit;
      end
   end

   // each NRZI transition steps the three-level cycle 0,+,0,-
   assign mlt_ph_d = (bit_stb && scr_bit) ? mlt_ph_q + MLT_PH_STEP : mlt_ph_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mlt_ph_q  <= '0;
         mlt_pos_q <= 1'b0;
         mlt_neg_q <= 1'b0;
      end else begin
         mlt_ph_q  <= mlt_ph_d;
         mlt_pos_q <= (mlt_ph_d == MLT_PH_POS);
         mlt_neg_q <= (mlt_ph_d == MLT_PH_NEG);
      end
   end

   // ****************************************
   // receive lookup
   // ****************************************
   cg_decoder u_cg_decoder (
      .code_group (rx_code_group),
      .in_frame   (rx_in_frame),
      .nibble     (dec_nibble),
      .error      (dec_err)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_nibble_q       <= '0;
         rx_error_q        <= 1'b0;
         rx_nibble_valid_q <= 1'b0;
      end else begin
         rx_nibble_valid_q <= rx_code_valid;
         if (rx_code_valid) begin
            rx_nibble_q <= dec_nibble;
            rx_error_q  <= dec_err;
         end else begin
            rx_error_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign mlt_pos         = mlt_pos_q;
   assign mlt_neg         = mlt_neg_q;
   assign tx_fifo_full    = tx_fifo_full_q;
   assign rx_nibble       = rx_nibble_q;
   assign rx_nibble_valid = rx_nibble_valid_q;
   assign rx_error        = rx_error_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   AST_LFSR_STEP: assert property (
      seeded && $past(seeded) && bit_stb && lfsr_q != '0 |=> lfsr_q == $past(lfsr_next))
      else $error("scrambler did not step by its polynomial");
   AST_LFSR_NONZERO: assert property (
      seeded |-> lfsr_q != '0)
      else $error("scrambler register holds all zeros");
   AST_SEED: assert property (
      $rose(seeded) |-> lfsr_q == $past(seed))
      else $error("scrambler seed not taken from address strap");
   AST_NRZI: assert property (
      bit_stb |=> (nrzi_q ^ $past(nrzi_q)) == $past(scr_bit))
      else $error("nrzi level did not follow scrambled bit");
   AST_MLT_EXCL: assert property (
      !(mlt_pos_q && mlt_neg_q))
      else $error("both drive streams high at once");
   AST_MLT_ALT: assert property (
      $fell(mlt_pos_q) |-> !mlt_pos_q until_with mlt_neg_q)
      else $error("positive pulse repeated before negative pulse");
   AST_CG_SLOT: assert property (
      cg_stb |=> !cg_stb [*8] ##1 !cg_stb ##1 cg_stb)
      else $error("code-group slot is not ten clocks");
   AST_JK: assert property (
      seeded && cg_stb && state_q == ST_IDLE && cur_en |=> cg_q == CG_J ##10 cg_q == CG_K)
      else $error("frame start not marked by J then K");
   AST_HALT: assert property (
      seeded && cg_stb && state_q == ST_DATA && cur_en && cur_er |=> cg_q == CG_HALT)
      else $error("errored nibble not replaced by HALT");
   AST_DATA: assert property (
      seeded && cg_stb && state_q == ST_DATA && cur_en && !cur_er |=> cg_q == $past(enc_cg))
      else $error("data nibble encoded to wrong code-group");
   AST_TR: assert property (
      seeded && cg_stb && state_q == ST_DATA && !cur_en |=> cg_q == CG_T ##10 cg_q == CG_R)
      else $error("frame end not marked by T then R");
   AST_IDLE: assert property (
      seeded && cg_stb && state_q == ST_IDLE && !cur_en |=> cg_q == CG_IDLE)
      else $error("idle not sent between frames");
   AST_RX_INVALID: assert property (
      rx_code_valid && dec_err |=> rx_error_q && rx_nibble_q == NIB_INVALID)
      else $error("invalid code-group not flagged with 6h");
   AST_RX_CTRL: assert property (
      rx_code_valid && rx_in_frame && rx_code_group == CG_IDLE |=> rx_error_q)
      else $error("idle inside data field not flagged");

endmodule

// ### testbench/mii_mac_model.sv
/*
   Behavioural MAC on the MII transmit side: one nibble each 25 MHz slot.
   Assumes a 250 MHz clk, so a slot is ten clocks; the bench calls send_frame.
*/
`timescale 1ns/1ps
module mii_mac_model
   import fe_tx_pkg::*;
(
   input  wire logic         clk,
   output logic              tx_en,
   output logic              tx_er,
   output logic [NIB_W-1:0]  txd
);
   // ****************************************
   // nibble slots
   // ****************************************
   initial begin
      tx_en = 1'b0;
      tx_er = 1'b0;
      txd   = 4'h0;
   end

   task automatic put(input logic en, input logic er, input logic [3:0] d);
      @(posedge clk);
      #1;
      tx_en = en;
      tx_er = er;
      // outside a frame the data pins toggle to the inverse of their last value
      txd   = en ? d : ~txd;
      repeat (9) @(posedge clk);
   endtask

   // bit i of er_mask flags nibble i, bit 31 the trailing idles
   task automatic send_frame(input logic [3:0] nibs[$], input logic [31:0] er_mask);
      int i;
      for (i = 0; i < nibs.size(); i++) put(1'b1, er_mask[i], nibs[i]);
      for (i = 0; i < 3; i++) put(1'b0, er_mask[31], 4'h0);
   endtask
endmodule

// ### testbench/fe_tx_coding_path_tb.sv
/*
   Self-checking bench: receive lookup table and transmitted frames decoded back
   from the three-level outputs. Assumes the MAC model and the design package.
*/
`timescale 1ns/1ps
module fe_tx_coding_path_tb
   import fe_tx_pkg::*;
;
   localparam cg_t dtab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   logic       clk, rstn, tx_en, tx_er, rx_code_valid, rx_in_frame;
   logic [3:0] txd, rx_nibble;
   logic [4:0] rx_code_group;
   logic       mlt_pos, mlt_neg, tx_fifo_full, rx_nibble_valid, rx_error;
   int         n_fail, samples_checked;
   int         lvl, prv, last_nz, par, cyc, nbits, bcnt;
   logic       mon_on, aligned;
   logic [10:0] ks;
   logic [4:0]  pb;
   logic [4:0]  strap;
   cg_t         got[$];

   mii_mac_model mac (.clk(clk), .tx_en(tx_en), .tx_er(tx_er), .txd(txd));

   fe_tx_coding_path dut (
      .clk(clk), .rstn(rstn), .tx_en(tx_en), .tx_er(tx_er), .txd(txd),
      .phy_address_strap(strap), .rx_code_group(rx_code_group),
      .rx_code_valid(rx_code_valid), .rx_in_frame(rx_in_frame),
      .mlt_pos(mlt_pos), .mlt_neg(mlt_neg), .tx_fifo_full(tx_fifo_full),
      .rx_nibble(rx_nibble), .rx_nibble_valid(rx_nibble_valid), .rx_error(rx_error));

   // ****************************************
   // compare and verdict
   // ****************************************
   task automatic cmp_bit(input logic g, input logic e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cmp_cg(input logic [4:0] g, input logic [4:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic give_verdict;
      $display("checks=%0d failures=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // line monitor: mlt-3 -> nrzi -> descramble -> code-groups
   // ****************************************
   task automatic mon_bit(input logic s);
      logic k;
      k = ks[10] ^ ks[8];
      // first bits train the key on idle
      if (nbits < 40) k = s ^ 1'b1;
      ks = {ks[9:0], k};
      nbits++;
      pb = {pb[3:0], s ^ k};
      if (nbits > 40 && !aligned && pb == CG_J) begin
         aligned = 1'b1;
         bcnt = 0;
         got.push_back(pb);
      end else if (nbits > 40 && aligned && ++bcnt == 5) begin
         bcnt = 0;
         got.push_back(pb);
         if (pb == CG_IDLE) aligned = 1'b0;
      end
   endtask

   always @(posedge clk) begin
      lvl = int'(mlt_pos) - int'(mlt_neg);
      cyc++;
      if (mlt_pos && mlt_neg) cmp_bit(1'b1, 1'b0);
      if (mon_on && par < 0 && lvl != prv) par = cyc % 2;
      if (par >= 0 && lvl != prv) cmp_bit(cyc % 2 == par, 1'b1);
      if (lvl != prv && lvl != 0) begin
         cmp_bit(prv == 0 && last_nz != lvl, 1'b1);
         last_nz = lvl;
      end
      if (mon_on && par >= 0 && cyc % 2 == par) mon_bit(lvl != prv);
      prv = lvl;
   end

   // ****************************************
   // scenarios
   // ****************************************
   function automatic logic [4:0] rx_exp(input logic [4:0] c, input logic f);
      int j;
      for (j = 0; j < 16; j++) if (dtab[j] == c) return {1'b0, j[3:0]};
      if (!f && (c == CG_IDLE || c == CG_T || c == CG_R)) return 5'h00;
      if (!f && (c == CG_J || c == CG_K)) return 5'h05;
      return 5'h16;
   endfunction

   // back to back lookups, every code out of and inside a frame
   task automatic run_rx;
      int i;
      for (i = 0; i < 64; i++) begin
         rx_code_group = i[4:0];
         rx_in_frame = i[5];
         rx_code_valid = 1'b1;
         @(posedge clk);
         #1;
         cmp_bit(rx_nibble_valid, 1'b1);
         cmp_cg({rx_error, rx_nibble}, rx_exp(i[4:0], i[5]));
      end
      rx_code_valid = 1'b0;
      @(posedge clk);
      #1;
      cmp_bit(rx_nibble_valid, 1'b0);
      cmp_bit(rx_error, 1'b0);
      cmp_cg({1'b0, rx_nibble}, 5'h06);
      $display("test rx lookup done");
   endtask

   task automatic run_frame(input logic [31:0] er_mask);
      logic [3:0] nibs[$];
      cg_t        exp[$];
      int         i;
      nibs = {4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'hd};
      for (i = 0; i < 16; i++) nibs.push_back(i[3:0]);
      exp = {CG_J, CG_K};
      for (i = 2; i < nibs.size(); i++) exp.push_back(er_mask[i] ? CG_HALT : dtab[nibs[i]]);
      exp.push_back(CG_T);
      exp.push_back(CG_R);
      exp.push_back(CG_IDLE);
      got.delete();
      mac.send_frame(nibs, er_mask);
      for (i = 0; i < 400 && got.size() < exp.size(); i++) @(posedge clk);
      cmp_cg(5'(got.size()), 5'(exp.size()));
      cmp_bit(tx_fifo_full, 1'b0);
      for (i = 0; i < exp.size() && i < got.size(); i++) begin
         cmp_cg(got[i], exp[i]);
      end
      $display("test frame mask=%h done", er_mask);
   endtask

   // mid-run reset with another strap; monitor retrains on the new key
   task automatic run_restrap;
      #1;
      {mon_on, aligned} = 2'b00;
      last_nz = 0;
      par = -1;
      rstn = 1'b0;
      strap = 5'h0c;
      repeat (10) @(posedge clk);
      #1;
      rstn = 1'b1;
      nbits = 0;
      bcnt = 0;
      repeat (100) @(posedge clk);
      mon_on = 1'b1;
      repeat (150) @(posedge clk);
      run_frame(32'h00000000);
      $display("test restrap done");
   endtask

   // ****************************************
   // clock, reset, sequence, watchdog
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("watchdog expired");
      give_verdict;
   end

   initial begin
      rstn = 1'b0;
      strap = 5'h13;
      rx_code_group = 5'h00;
      rx_code_valid = 1'b0;
      rx_in_frame = 1'b0;
      {n_fail, samples_checked, prv, last_nz, cyc, nbits, bcnt} = '0;
      par = -1;
      mon_on = 1'b0;
      aligned = 1'b0;
      ks = '0;
      pb = 5'h1f;
      repeat (10) @(posedge clk);
      #1;
      rstn = 1'b1;
      run_rx;
      repeat (100) @(posedge clk);
      mon_on = 1'b1;
      repeat (150) @(posedge clk);
      run_frame(32'h00000000);
      run_frame(32'h00000c30);
      run_frame(32'hffffffff);
      run_restrap;
      give_verdict;
   end
endmodule
